//--- ltso_core.sv
`timescale 1ns/1ps
module ltso_core #(
    parameter int US_CYCLES = 25   // Clock cycles per microsecond
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        wr_en_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [12:0] wdata_in,
    input  wire logic        cluster_call_in,
    input  wire logic [5:0]  rx_cluster_in,
    input  wire logic        cmd_valid_in,
    input  wire logic        flag_clear_in,
    input  wire logic [11:0] dim_switch_in,
    input  wire logic [11:0] fault_raw_in,
    output logic      [12:0] rdata_out,
    output logic             cluster_accept_out,
    output logic             timeout_flag_out,
    output logic             fault_output_out,
    output logic      [11:0] switch_closed_out,
    output logic      [11:0] fault_event_out,
    output logic      [8:0]  short_thresh_out
);
    logic [8:0]  thresh_r;
    logic [3:0]  tsel_r;
    logic [5:0]  cid_r;
    logic [11:0] pattern_r;
    logic [11:0] force_r;
    logic [31:0] cnt_r;
    logic        flag_r;
    logic [11:0] sw_prev_r;

    // Register index decode, shared by the write strobes and the read mux
    function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
        return a == idx;
    endfunction : hit

    // Write decode; a cluster call only lands when the id matches
    wire id_match = rx_cluster_in == cid_r;
    wire wr_ok    = wr_en_in && (!cluster_call_in || id_match);
    wire wr_th    = wr_ok && hit(addr_in, ltso_pkg::ADDR_THRESH);
    wire wr_link  = wr_ok && hit(addr_in, ltso_pkg::ADDR_LINK);
    wire wr_pat   = wr_ok && hit(addr_in, ltso_pkg::ADDR_PATTERN);
    wire wr_frc   = wr_ok && hit(addr_in, ltso_pkg::ADDR_FORCE);
    wire [31:0] limit = 32'(ltso_pkg::timeout_us(tsel_r) * US_CYCLES);
    wire armed    = tsel_r != 4'h0;
    wire expire   = armed && !flag_r && cnt_r >= limit - 32'h1;

    // override forces closed; fail-safe wins; normal otherwise
    wire [11:0] sw_nxt = flag_r ? pattern_r : (force_r | dim_switch_in);
    wire [11:0] opening = sw_prev_r & ~sw_nxt;

    // Register read mux, unused bits read zero
    wire [12:0] rd_nxt =
        hit(addr_in, ltso_pkg::ADDR_THRESH)  ? {4'h0, thresh_r} :
        hit(addr_in, ltso_pkg::ADDR_LINK)    ? {3'h0, tsel_r, cid_r} :
        hit(addr_in, ltso_pkg::ADDR_PATTERN) ? {1'b0, pattern_r} :
        hit(addr_in, ltso_pkg::ADDR_FORCE)   ? {1'b0, force_r} : 13'h0000;

    // Configuration registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            thresh_r  <= 9'h000;
            tsel_r    <= 4'h0;
            cid_r     <= ltso_pkg::CID_RESET;
            pattern_r <= 12'h000;
            force_r   <= 12'h000;
        end else begin
            if (wr_th) thresh_r <= wdata_in[8:0];
            if (wr_link) begin
                tsel_r <= wdata_in[9:ltso_pkg::TSEL_LSB];
                cid_r  <= wdata_in[ltso_pkg::CID_MSB:0];
            end
            if (wr_pat) pattern_r <= wdata_in[11:0];
            if (wr_frc) force_r <= wdata_in[11:0];
        end
    end

    // Inactivity timer and sticky flag; expiry beats a same-cycle clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r  <= 32'h0;
            flag_r <= 1'b0;
        end else begin
            if (cmd_valid_in || wr_link || !armed || flag_r) cnt_r <= 32'h0;
            else cnt_r <= cnt_r + 32'h1;
            if (expire) flag_r <= 1'b1;
            else if (flag_clear_in) flag_r <= 1'b0;
        end
    end

    // Outputs registered; fault events only on opening edges
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out          <= 13'h0000;
            cluster_accept_out <= 1'b0;
            fault_output_out   <= 1'b0;
            switch_closed_out  <= 12'h000;
            sw_prev_r          <= 12'h000;
            fault_event_out    <= 12'h000;
        end else begin
            rdata_out          <= rd_nxt;
            cluster_accept_out <= wr_en_in && cluster_call_in && id_match;
            fault_output_out   <= expire || (flag_r && !flag_clear_in);
            switch_closed_out  <= sw_nxt;
            sw_prev_r          <= sw_nxt;
            fault_event_out    <= opening & fault_raw_in;
        end
    end

    assign timeout_flag_out = flag_r;
    assign short_thresh_out = thresh_r;

    AST_FAULT_PIN: assert property (@(posedge clk_in) disable iff (rst_in)
        fault_output_out == flag_r)
        else $error("fault pin differs from flag");
    AST_PATTERN: assert property (@(posedge clk_in) disable iff (rst_in)
        flag_r |=> switch_closed_out == $past(pattern_r))
        else $error("fail-safe pattern not applied");
    AST_FORCE: assert property (@(posedge clk_in) disable iff (rst_in)
        !flag_r |=> (switch_closed_out & $past(force_r)) == $past(force_r))
        else $error("overridden switch not closed");
    AST_DISABLED: assert property (@(posedge clk_in) disable iff (rst_in)
        !armed && !flag_r |=> !flag_r)
        else $error("flag set while disabled");
    AST_CID: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_en_in && cluster_call_in && !id_match |=> $stable(force_r))
        else $error("foreign cluster write landed");
    AST_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
        cmd_valid_in |=> cnt_r == 32'h0)
        else $error("timer not restarted");
    AST_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
        flag_r && !flag_clear_in |=> flag_r)
        else $error("flag dropped without clear");
    AST_EXPIRE: assert property (@(posedge clk_in) disable iff (rst_in)
        expire |=> flag_r)
        else $error("timeout did not set flag");
    AST_OPEN_ONLY: assert property (@(posedge clk_in) disable iff (rst_in)
        (fault_event_out & ~$past(opening)) == 12'h000)
        else $error("fault outside opening edge");

    COV_TIMEOUT: cover property (@(posedge clk_in) disable iff (rst_in)
        $rose(flag_r));
    COV_CLEAR: cover property (@(posedge clk_in) disable iff (rst_in)
        $fell(flag_r));
    COV_CLUSTER: cover property (@(posedge clk_in) disable iff (rst_in)
        cluster_accept_out);
    COV_EVENT: cover property (@(posedge clk_in) disable iff (rst_in)
        fault_event_out != 12'h000);

    // normal control when no override and no timeout
    AST_NORMAL: assert property (@(posedge clk_in) disable iff (rst_in)
        !flag_r |=> switch_closed_out ==
            ($past(force_r) | $past(dim_switch_in)))
        else $error("switch not under normal control");

    AST_LINK_WR: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_link |=> tsel_r == $past(wdata_in[9:ltso_pkg::TSEL_LSB]) &&
            cid_r == $past(wdata_in[ltso_pkg::CID_MSB:0]))
        else $error("link register write lost");

    AST_THRESH_WR: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_th |=> short_thresh_out == $past(wdata_in[8:0]))
        else $error("threshold write lost");

    // a clear with no expiry drops the flag
    AST_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
        flag_r && flag_clear_in |=> !flag_r)
        else $error("flag survived clear");

    AST_SEL_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_link |=> cnt_r == 32'h0)
        else $error("timer not restarted by selector write");

    // no flag before the full silent interval
    AST_NO_EARLY: assert property (@(posedge clk_in) disable iff (rst_in)
        armed && !flag_r && cnt_r < limit - 32'h1 |=> !flag_r)
        else $error("flag set before timeout");

    // a forced switch never opens while no timeout flag is set, so never reports
    AST_FORCE_QUIET: assert property (@(posedge clk_in) disable iff (rst_in)
        !flag_r |=> (fault_event_out & $past(force_r)) == 12'h000)
        else $error("fault event on forced switch");

    // an accept only follows a matching id
    AST_ACCEPT: assert property (@(posedge clk_in) disable iff (rst_in)
        cluster_accept_out |-> $past(rx_cluster_in) == $past(cid_r))
        else $error("cluster call accepted with foreign id");

    // Timer restarts whenever the selector code is written; a mid-run code change
    // takes effect at once because the write also restarts the count
    COV_ARMED_CMD: cover property (@(posedge clk_in) disable iff (rst_in)
        armed && cmd_valid_in);
endmodule : ltso_core

//--- ltso_pkg.sv
// Function
// - Three-bit short thresholds for switches nine to eleven
// - Link register holds timeout selector and cluster id
// - Selector zero disables link supervision
// - Selector codes map to timeouts up to 5s
// - Fault output follows timeout flag
// - Timeout flag applies fail-safe switch pattern
// - Override bit forces switch closed while no timeout flag is set
// - Clear override leaves normal dimming control
// - Faults sampled only when switch opens
package ltso_pkg;
    localparam int          NSW          = 12;
    localparam logic [3:0]  ADDR_THRESH  = 4'h6;
    localparam logic [3:0]  ADDR_LINK    = 4'h7;
    localparam logic [3:0]  ADDR_PATTERN = 4'h8;
    localparam logic [3:0]  ADDR_FORCE   = 4'h9;
    localparam logic [5:0]  CID_RESET    = 6'h01;
    localparam int          TSEL_LSB     = 6;
    localparam int          CID_MSB      = 5;
    localparam int          REG_W        = 13;
    localparam int          CLK_KHZ      = 25000;
    localparam int          CNT_W        = 27;

    // Timeout in microseconds for each selector code
    function automatic int timeout_us(input logic [3:0] sel);
        unique case (sel)
            4'h1: return 200;
            4'h2: return 500;
            4'h3: return 1000;
            4'h4: return 2000;
            4'h5: return 5000;
            4'h6: return 10000;
            4'h7: return 20000;
            4'h8: return 50000;
            4'h9: return 100000;
            4'ha: return 200000;
            4'hb: return 500000;
            4'hc: return 1000000;
            4'hd: return 2000000;
            4'he: return 5000000;
            4'hf: return 5000000;
            4'h0: return 0;
        endcase
    endfunction : timeout_us
endpackage : ltso_pkg

//--- ltso_host.sv
`timescale 1ns/1ps
// Host model: register writes and link events, changed at falling edge
module ltso_host (
    input  wire logic        clk_in,
    output logic             wr_en_out,
    output logic      [3:0]  addr_out,
    output logic      [12:0] wdata_out,
    output logic             call_out,
    output logic      [5:0]  cid_out,
    output logic             cmd_out,
    output logic             clr_out
);
    initial begin
        {wr_en_out, addr_out, wdata_out, call_out, cid_out} = '0;
        {cmd_out, clr_out} = '0;
    end
    // writes while stopped
    // Overrides are written only with switches held, never mid-frame
    task automatic wr(input logic [3:0] a, input logic [12:0] d,
                      input logic c, input logic [5:0] id);
        @(negedge clk_in);
        {wr_en_out, addr_out, wdata_out, call_out, cid_out} = {1'b1, a, d, c, id};
        @(negedge clk_in);
        {wr_en_out, call_out} = '0;
    endtask : wr
    // Read select held until the next request
    task automatic sel(input logic [3:0] a);
        @(negedge clk_in);
        addr_out = a;
    endtask : sel
    // One-cycle link event pulses
    task automatic pulse(input logic cmd, input logic clr);
        @(negedge clk_in);
        {cmd_out, clr_out} = {cmd, clr};
        @(negedge clk_in);
        {cmd_out, clr_out} = '0;
    endtask : pulse
endmodule : ltso_host

//--- link_timeout_switch_override_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin error_cnt++; \
    $display("wrong value %s exp %h seen %h", n, e, s); end end
module link_timeout_switch_override_bench;
    logic        clk_in, rst_in, chk_r, we, call, cmd, clr, acc, flag, fault_output;
    logic [3:0]  addr;
    logic [5:0]  id, cluster_ident;
    logic [12:0] wd, rdata;
    logic [31:0] v;
    logic [11:0] dim, raw, sw, fev, f, pat;
    logic [8:0]  thr;
    logic [17:0] q[$], n;
    logic [31:0] seed = 32'h0000aeb3;
    int          error_cnt = 0, compares = 0, t;
    ltso_host ltso_host_i (.clk_in(clk_in), .wr_en_out(we), .addr_out(addr),
        .wdata_out(wd), .call_out(call), .cid_out(id), .cmd_out(cmd),
        .clr_out(clr));
    ltso_core #(.US_CYCLES(1)) ltso_core_i (.clk_in(clk_in), .rst_in(rst_in),
        .wr_en_in(we), .addr_in(addr), .wdata_in(wd), .cluster_call_in(call),
        .rx_cluster_in(id), .cmd_valid_in(cmd), .flag_clear_in(clr),
        .dim_switch_in(dim), .fault_raw_in(raw), .rdata_out(rdata),
        .cluster_accept_out(acc), .timeout_flag_out(flag),
        .fault_output_out(fault_output), .switch_closed_out(sw),
        .fault_event_out(fev), .short_thresh_out(thr));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Note an expectation; the watcher compares at the next rising edge
    task automatic note(input logic [1:0] s, input logic [15:0] e, input bit now);
        if (!now) @(negedge clk_in);
        q.push_back({s, e});
        chk_r = 1'b1;
        @(negedge clk_in);
        chk_r = 1'b0;
    endtask : note
    task automatic rd(input logic [3:0] a, input logic [12:0] e);
        ltso_host_i.sel(a);
        note(2'h0, {3'h0, e}, 0);
    endtask : rd
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Watcher: oldest note against the outputs it names
    always @(posedge clk_in) if (chk_r === 1'b1) begin
        n = q.pop_front();
        case (n[17:16])
            2'h0: `CHK("rdata", n[12:0], rdata)
            2'h1: `CHK("switches", n[13:0], {flag, fault_output, sw})
            2'h2: `CHK("thresh", n[8:0], thr)
            default: `CHK("accept", n[12:0], {fev, acc})
        endcase
    end
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Watchdog sized well past the roughly 1300 cycles of the run
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {rst_in, chk_r, dim, raw} = {1'b1, 1'b0, 24'h0};
        repeat (4) @(posedge clk_in);
        @(negedge clk_in) rst_in = 1'b0;
        rd(ltso_pkg::ADDR_LINK, 13'h0001);
        rd(ltso_pkg::ADDR_FORCE, 13'h0000);
        repeat (300) @(negedge clk_in);
        note(2'h1, 16'h0000, 0);
        $display("reset test done");
        for (int k = 0; k < 8; k++) begin
            ltso_host_i.wr(ltso_pkg::ADDR_THRESH, {4'h0, {3{k[2:0]}}}, 0, 0);
            note(2'h2, {7'h0, {3{k[2:0]}}}, 0);
        end
        v = rnd(); cluster_ident = v[5:0]; pat = v[12:1];
        ltso_host_i.wr(ltso_pkg::ADDR_LINK, {7'h0, cluster_ident}, 0, 0);
        rd(ltso_pkg::ADDR_LINK, {7'h0, cluster_ident});
        v = rnd(); f = v[11:0]; dim = v[23:12]; raw = v[31:20];
        ltso_host_i.wr(ltso_pkg::ADDR_FORCE, {1'b0, f}, 0, 0);
        rd(ltso_pkg::ADDR_FORCE, {1'b0, f});
        note(2'h1, {4'h0, f | dim}, 0);
        rd(4'ha, 13'h0000);
        dim = 12'h000;
        note(2'h3, {3'h0, v[23:12] & ~f & raw, 1'b0}, 0);
        $display("register test done");
        ltso_host_i.wr(ltso_pkg::ADDR_PATTERN, {1'b0, pat}, 1, cluster_ident);
        note(2'h3, 16'h0001, 1);
        ltso_host_i.wr(ltso_pkg::ADDR_PATTERN, {1'b0, ~pat}, 1, ~cluster_ident);
        note(2'h3, 16'h0000, 1);
        rd(ltso_pkg::ADDR_PATTERN, {1'b0, pat});
        $display("cluster test done");
        for (int k = 1; k < 3; k++) begin
            t = (k == 1) ? 200 : 500;
            ltso_host_i.wr(ltso_pkg::ADDR_LINK, {3'h0, k[3:0], cluster_ident}, 0, 0);
            repeat (100) @(negedge clk_in);
            ltso_host_i.pulse(1, 0);
            repeat (t - 12) @(negedge clk_in);
            note(2'h1, {4'h0, f | dim}, 0);
            repeat (20) @(negedge clk_in);
            note(2'h1, {4'h3, pat}, 0);
            ltso_host_i.pulse(1, 1);
            note(2'h1, {4'h0, f | dim}, 0);
        end
        $display("timeout test done");
        give_verdict();
    end
endmodule : link_timeout_switch_override_bench
